/* File: hw/etpg_top.sv */
// Function
// - Frame holds header, payload, unique sequence number.
// - Checksum appended after delayed stream, then emitted.
// - No preamble, delimiter or MAC check sequence.
// - Field order: addresses, type, sequence, payload, CRC.
// - Transmit status and sent packet count readable.
// - Monitor sink accepts packets into checker.
// - Monitor recomputes CRC and compares with field.
// - Good or corrupted indication, statistics updated.
// - Writable expected packet count for monitor.
// - Good, bad, byte and cycle counts readable.
// - Everything runs from one system clock.
// - One active-low reset initialises all logic.
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "etpg_map.svh"
module etpg_top (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Wishbone register slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Byte stream source towards the MAC.
  output etpg_pkg::etpg_st_s tx_o,
  input wire logic tx_ready,
  // Byte stream sink from the MAC.
  input wire etpg_pkg::etpg_st_s rx_i,
  output logic rx_ready,
  // Packet verdict pulses and interrupt.
  output logic pkt_good,
  output logic pkt_bad,
  output logic irq
);
  import etpg_pkg::*;

  // One byte step of the reflected CRC-32, shared by both directions.
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `ETPG_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // Merges new bytes into old ones where the byte select is set.
  function automatic logic [31:0] wmask(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : wmask

  // Software settings.
  logic [31:0] gen_num_q; // Packets per generator run.
  logic [13:0] gen_pay_q; // Payload bytes per packet.
  logic [47:0] da_q; // Destination address.
  logic [47:0] sa_q; // Source address.
  logic [15:0] etype_q; // Length or type field.
  logic [31:0] mon_exp_q; // Packets the monitor expects.
  logic [3:0] irq_mask_q; // Interrupt enables.
  logic [3:0] irq_stat_q; // Sticky interrupt events.
  // Generator state.
  etpg_gen_e gst_q; // Sequencer state.
  logic [13:0] gen_idx_q; // Byte index inside the frame.
  logic [13:0] gen_plen_q; // Payload length latched at start.
  logic [31:0] gen_left_q; // Packets still to be produced.
  logic [15:0] seq_q; // Running sequence number.
  logic [31:0] gcrc_q; // Generator checksum accumulator.
  logic [1:0] crc_cnt_q; // Which checksum byte goes out next.
  logic [31:0] txcnt_q; // Packets fully accepted by the MAC.
  etpg_st_s dl_q [`ETPG_DLY]; // Tapped delay line of beats.
  // Monitor state.
  logic mon_busy_q; // A monitor run is in progress.
  logic [31:0] mcrc_q; // Receive checksum accumulator.
  logic [31:0] good_q; // Frames with a valid checksum.
  logic [31:0] bad_q; // Frames with a corrupted checksum.
  logic [31:0] bytes_q; // Bytes taken during the run.
  logic [31:0] cyc_q; // Clock cycles spent in the run.
  // Bus decode.
  logic req; // A new bus request in this cycle.
  logic wr; // A new bus write.
  logic [7:0] adr; // Word aligned byte address.
  logic [31:0] rd_d; // Current content of the addressed word.
  logic [31:0] wdat; // Written word merged under byte select.
  logic [31:0] w1 ; // Ones written, for strobe and clear bits.
  // Stream helpers.
  logic adv; // The output stage may take a new beat.
  logic tx_fire; // A beat leaves towards the MAC.
  etpg_st_s beat; // Beat produced in this cycle.
  logic [13:0] flen; // Header plus payload length.
  logic [31:0] fcs; // Inverted checksum to be sent.
  logic gen_start; // Software starts a generator run.
  logic gen_done; // Last packet of a run accepted.
  logic mon_start; // Software starts a monitor run.
  logic [31:0] rx_crc; // Checksum including the current byte.
  logic rx_eop_fire; // Last byte of a received frame.
  logic rx_ok; // That frame's checksum is intact.
  logic [3:0] irq_ev; // Events raised in this cycle.

  // A request is answered one cycle after it is taken.
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign adr = {wb_adr_i[7:2], 2'b00};
  assign wdat = wmask(rd_d, wb_dat_i, wb_sel_i);
  assign w1 = wmask(`ETPG_RST_32, wb_dat_i, wb_sel_i);

  // Read view of every register; unmapped words read as zero.
  always_comb begin
    case (adr)
      `ETPG_GEN_NUM: rd_d = gen_num_q;
      `ETPG_GEN_PAY: rd_d = {18'h0_0000, gen_pay_q};
      `ETPG_GEN_STAT: rd_d = {31'h0000_0000,
                              gst_q != G_IDLE || tx_o.valid};
      `ETPG_GEN_TXCNT: rd_d = txcnt_q;
      `ETPG_GEN_DA_HI: rd_d = {16'h0000, da_q[47:32]};
      `ETPG_GEN_DA_LO: rd_d = da_q[31:0];
      `ETPG_GEN_SA_HI: rd_d = {16'h0000, sa_q[47:32]};
      `ETPG_GEN_SA_LO: rd_d = sa_q[31:0];
      `ETPG_GEN_ETYPE: rd_d = {16'h0000, etype_q};
      `ETPG_MON_EXP: rd_d = mon_exp_q;
      `ETPG_MON_STAT: rd_d = {31'h0000_0000, mon_busy_q};
      `ETPG_MON_GOOD: rd_d = good_q;
      `ETPG_MON_BAD: rd_d = bad_q;
      `ETPG_MON_BYTES: rd_d = bytes_q;
      `ETPG_MON_CYC: rd_d = cyc_q;
      `ETPG_IRQ_STAT: rd_d = {28'h000_0000, irq_stat_q};
      `ETPG_IRQ_MASK: rd_d = {28'h000_0000, irq_mask_q};
      default: rd_d = `ETPG_RST_32;
    endcase
  end

  // Bus answer: ack for one cycle, read data from a flip-flop.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `ETPG_RST_32;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rd_d;
      end
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gen_num_q <= `ETPG_RST_32;
      gen_pay_q <= `ETPG_RST_PAY;
      da_q <= `ETPG_RST_48;
      sa_q <= `ETPG_RST_48;
      etype_q <= `ETPG_RST_16;
      mon_exp_q <= `ETPG_RST_32;
      irq_mask_q <= 4'h0;
    end else if (wr) begin
      case (adr)
        `ETPG_GEN_NUM: gen_num_q <= wdat;
        `ETPG_GEN_PAY: gen_pay_q <= wdat[13:0];
        `ETPG_GEN_DA_HI: da_q[47:32] <= wdat[15:0];
        `ETPG_GEN_DA_LO: da_q[31:0] <= wdat;
        `ETPG_GEN_SA_HI: sa_q[47:32] <= wdat[15:0];
        `ETPG_GEN_SA_LO: sa_q[31:0] <= wdat;
        `ETPG_GEN_ETYPE: etype_q <= wdat[15:0];
        `ETPG_MON_EXP: mon_exp_q <= wdat;
        `ETPG_IRQ_MASK: irq_mask_q <= wdat[3:0];
        default: ;
      endcase
    end
  end

  // Start strobes; a generator start while a run is active is ignored, a monitor start restarts the run.
  assign gen_start = wr && adr == `ETPG_GEN_CTRL && w1[0] &&
                     gst_q == G_IDLE && gen_num_q != `ETPG_RST_32;
  assign mon_start = wr && adr == `ETPG_MON_CTRL && w1[0];

  // The whole source pipe moves only when the output stage is free.
  assign adv = ~tx_o.valid | tx_ready;
  assign tx_fire = tx_o.valid & tx_ready;
  assign flen = `ETPG_HDR_LEN + gen_plen_q;
  assign fcs = ~gcrc_q;

  // Byte at the current frame index: header, sequence, then payload.
  always_comb begin
    beat.valid = gst_q == G_FRAME;
    beat.sop = gen_idx_q == 14'h0000;
    beat.eop = gen_idx_q == flen - 14'h0001;
    if (gen_idx_q < 14'h0006) begin
      beat.data = da_q[8*(5 - gen_idx_q[2:0]) +: 8];
    end else if (gen_idx_q < 14'h000C) begin
      beat.data = sa_q[8*(11 - gen_idx_q[3:0]) +: 8];
    end else if (gen_idx_q < 14'h000E) begin
      beat.data = etype_q[8*(13 - gen_idx_q[3:0]) +: 8];
    end else if (gen_idx_q < `ETPG_HDR_LEN) begin
      beat.data = seq_q[8*(15 - gen_idx_q[3:0]) +: 8];
    end else begin
      // Incrementing payload, starting from zero after the header.
      beat.data = gen_idx_q[7:0] - 8'h10;
    end
  end

  // Generator sequencer. Production waits in FLUSH until the last
  // data byte leaves the delay line, then the checksum follows.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gst_q <= G_IDLE;
      gen_idx_q <= 14'h0000;
      gen_plen_q <= `ETPG_RST_PAY;
      gen_left_q <= `ETPG_RST_32;
      crc_cnt_q <= 2'h0;
    end else begin
      case (gst_q)
        G_IDLE: begin
          if (gen_start) begin
            gst_q <= G_FRAME;
            gen_idx_q <= 14'h0000;
            gen_left_q <= gen_num_q;
            // Oversized settings are clamped to the jumbo limit.
            gen_plen_q <= (gen_pay_q > `ETPG_MAX_PAY) ?
                          `ETPG_MAX_PAY : gen_pay_q;
          end
        end
        G_FRAME: begin
          if (adv) begin
            if (beat.eop) begin
              gen_idx_q <= 14'h0000;
              gen_left_q <= gen_left_q - 32'h0000_0001;
              gst_q <= G_FLUSH;
            end else begin
              gen_idx_q <= gen_idx_q + 14'h0001;
            end
          end
        end
        G_FLUSH: begin
          if (adv && dl_q[`ETPG_DLY-1].valid && dl_q[`ETPG_DLY-1].eop) begin
            gst_q <= G_CRC;
            crc_cnt_q <= 2'h0;
          end
        end
        G_CRC: begin
          if (adv) begin
            crc_cnt_q <= crc_cnt_q + 2'h1;
            if (crc_cnt_q == 2'h3) begin
              gst_q <= (gen_left_q != `ETPG_RST_32) ? G_FRAME : G_IDLE;
            end
          end
        end
        default: gst_q <= G_IDLE;
      endcase
    end
  end

  // Sequence number steps once per produced packet and wraps.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seq_q <= `ETPG_RST_16;
    end else if (gst_q == G_FRAME && adv && beat.eop) begin
      seq_q <= seq_q + 16'h0001;
    end
  end

  // Checksum runs alongside production; the frame itself waits in
  // the delay line, so the checksum is final before its tail exits.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gcrc_q <= `ETPG_CRC_INIT;
    end else if (beat.valid && adv) begin
      gcrc_q <= crc_byte(beat.sop ? `ETPG_CRC_INIT : gcrc_q,
                         beat.data);
    end
  end

  // Tapped delay line; bubbles enter while nothing is produced.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < `ETPG_DLY; i++) begin
        dl_q[i] <= '0;
      end
    end else if (adv) begin
      dl_q[0] <= beat;
      for (int i = 1; i < `ETPG_DLY; i++) begin
        dl_q[i] <= dl_q[i-1];
      end
    end
  end

  // Output stage: delayed bytes, then the checksum low byte first.
  // No preamble or MAC check sequence is ever produced here.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_o <= '0;
    end else if (adv) begin
      if (gst_q == G_CRC) begin
        tx_o.valid <= 1'b1;
        tx_o.sop <= 1'b0;
        tx_o.eop <= crc_cnt_q == 2'h3;
        tx_o.data <= fcs[8*crc_cnt_q +: 8];
      end else begin
        tx_o.valid <= dl_q[`ETPG_DLY-1].valid;
        tx_o.sop <= dl_q[`ETPG_DLY-1].sop;
        tx_o.eop <= 1'b0;
        tx_o.data <= dl_q[`ETPG_DLY-1].data;
      end
    end
  end

  // Count of packets accepted by the MAC during the run.
  assign gen_done = tx_fire && tx_o.eop &&
                    txcnt_q + 32'h0000_0001 == gen_num_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txcnt_q <= `ETPG_RST_32;
    end else if (gen_start) begin
      txcnt_q <= `ETPG_RST_32;
    end else if (tx_fire && tx_o.eop) begin
      txcnt_q <= txcnt_q + 32'h0000_0001;
    end
  end

  // The monitor never stalls the MAC; every byte is checked.
  assign rx_ready = 1'b1;
  assign rx_crc = crc_byte(rx_i.sop ? `ETPG_CRC_INIT : mcrc_q,
                           rx_i.data);
  assign rx_eop_fire = rx_i.valid & rx_i.eop;
  // Running over data and its checksum leaves a fixed residue.
  assign rx_ok = rx_crc == `ETPG_CRC_RES;

  // Receive checksum accumulator and verdict pulses.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mcrc_q <= `ETPG_CRC_INIT;
      pkt_good <= 1'b0;
      pkt_bad <= 1'b0;
    end else begin
      if (rx_i.valid) begin
        mcrc_q <= rx_crc;
      end
      pkt_good <= rx_eop_fire & rx_ok;
      pkt_bad <= rx_eop_fire & ~rx_ok;
    end
  end

  // Monitor statistics; counted only during a run so that software
  // divides bytes by cycles of the same window.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mon_busy_q <= 1'b0;
      good_q <= `ETPG_RST_32;
      bad_q <= `ETPG_RST_32;
      bytes_q <= `ETPG_RST_32;
      cyc_q <= `ETPG_RST_32;
    end else if (mon_start) begin
      mon_busy_q <= mon_exp_q != `ETPG_RST_32;
      good_q <= `ETPG_RST_32;
      bad_q <= `ETPG_RST_32;
      bytes_q <= `ETPG_RST_32;
      cyc_q <= `ETPG_RST_32;
    end else if (mon_busy_q) begin
      cyc_q <= cyc_q + 32'h0000_0001;
      if (rx_i.valid) begin
        bytes_q <= bytes_q + 32'h0000_0001;
      end
      if (rx_eop_fire) begin
        if (rx_ok) begin
          good_q <= good_q + 32'h0000_0001;
        end else begin
          bad_q <= bad_q + 32'h0000_0001;
        end
        if (good_q + bad_q + 32'h0000_0001 == mon_exp_q) begin
          mon_busy_q <= 1'b0;
        end
      end
    end
  end

  // Sticky interrupt status; a new event wins over a clear.
  assign irq_ev[`ETPG_IRQ_GEN_DONE] = gen_done;
  assign irq_ev[`ETPG_IRQ_MON_GOOD] = rx_eop_fire & rx_ok;
  assign irq_ev[`ETPG_IRQ_MON_BAD] = rx_eop_fire & ~rx_ok;
  assign irq_ev[`ETPG_IRQ_MON_DONE] = mon_busy_q & rx_eop_fire &
    (good_q + bad_q + 32'h0000_0001 == mon_exp_q);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_stat_q <= 4'h0;
    end else if (wr && adr == `ETPG_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~w1[3:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // Accepted byte count of the frame on the source, for checking.
  logic [13:0] tx_len_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_len_q <= 14'h0000;
    end else if (tx_fire) begin
      tx_len_q <= tx_o.eop ? 14'h0000 : tx_len_q + 14'h0001;
    end
  end

  property p_wb_ack;
    @(posedge mclk) disable iff (!rst_n)
      req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus ack not one cycle");

  property p_seq_step;
    @(posedge mclk) disable iff (!rst_n)
      (gst_q == G_FRAME && adv && beat.eop) |=>
        seq_q == $past(seq_q) + 16'h0001;
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("sequence number did not step");

  property p_tx_len;
    @(posedge mclk) disable iff (!rst_n)
      (tx_fire && tx_o.eop) |-> tx_len_q == flen + 14'h0003;
  endproperty
  a_tx_len: assert property (p_tx_len)
    else $error("emitted frame length wrong");

  property p_first_byte;
    @(posedge mclk) disable iff (!rst_n)
      (tx_fire && tx_o.sop) |-> tx_o.data == da_q[47:40];
  endproperty
  a_first_byte: assert property (p_first_byte)
    else $error("frame does not open with destination");

  property p_tx_hold;
    @(posedge mclk) disable iff (!rst_n)
      (tx_o.valid && !tx_ready) |=> $stable(tx_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("source beat changed while stalled");

  property p_crc_drained;
    @(posedge mclk) disable iff (!rst_n)
      (gst_q == G_CRC) |-> !dl_q[`ETPG_DLY-1].valid && !beat.valid;
  endproperty
  a_crc_drained: assert property (p_crc_drained)
    else $error("checksum sent before delayed data");

  property p_txcnt;
    @(posedge mclk) disable iff (!rst_n)
      (tx_fire && tx_o.eop && !gen_start) |=>
        txcnt_q == $past(txcnt_q) + 32'h0000_0001;
  endproperty
  a_txcnt: assert property (p_txcnt)
    else $error("sent packet count did not step");

  property p_verdict;
    @(posedge mclk) disable iff (!rst_n)
      rx_eop_fire |=> (pkt_good ^ pkt_bad) ##1 !(pkt_good | pkt_bad);
  endproperty
  a_verdict: assert property (p_verdict)
    else $error("verdict pulse missing or doubled");

  property p_good_count;
    @(posedge mclk) disable iff (!rst_n)
      (mon_busy_q && rx_eop_fire && rx_ok && !mon_start) |=>
        good_q == $past(good_q) + 32'h0000_0001 && pkt_good;
  endproperty
  a_good_count: assert property (p_good_count)
    else $error("good frame not counted");

  property p_cycles;
    @(posedge mclk) disable iff (!rst_n)
      (mon_busy_q && !mon_start) |=>
        cyc_q == $past(cyc_q) + 32'h0000_0001;
  endproperty
  a_cycles: assert property (p_cycles)
    else $error("cycle count did not step");

  c_frame_out: cover property (@(posedge mclk) tx_fire && tx_o.eop);
  c_good: cover property (@(posedge mclk) pkt_good);
  c_bad: cover property (@(posedge mclk) pkt_bad);
  c_gen_done: cover property (@(posedge mclk) gen_done);
endmodule : etpg_top

/* File: hw/etpg_map.svh */
`ifndef ETPG_MAP_SVH
`define ETPG_MAP_SVH
// Register byte offsets on the Wishbone slave.
`define ETPG_GEN_NUM 8'h00
`define ETPG_GEN_PAY 8'h04
`define ETPG_GEN_CTRL 8'h08
`define ETPG_GEN_STAT 8'h0C
`define ETPG_GEN_TXCNT 8'h10
`define ETPG_GEN_DA_HI 8'h14
`define ETPG_GEN_DA_LO 8'h18
`define ETPG_GEN_SA_HI 8'h1C
`define ETPG_GEN_SA_LO 8'h20
`define ETPG_GEN_ETYPE 8'h24
`define ETPG_MON_EXP 8'h40
`define ETPG_MON_CTRL 8'h44
`define ETPG_MON_STAT 8'h48
`define ETPG_MON_GOOD 8'h4C
`define ETPG_MON_BAD 8'h50
`define ETPG_MON_BYTES 8'h54
`define ETPG_MON_CYC 8'h58
`define ETPG_IRQ_STAT 8'h60
`define ETPG_IRQ_MASK 8'h64
// Interrupt bit positions, shared by status and mask.
`define ETPG_IRQ_GEN_DONE 0
`define ETPG_IRQ_MON_GOOD 1
`define ETPG_IRQ_MON_BAD 2
`define ETPG_IRQ_MON_DONE 3
// Reset values.
`define ETPG_RST_32 32'h0000_0000
`define ETPG_RST_48 48'h0000_0000_0000
`define ETPG_RST_16 16'h0000
`define ETPG_RST_PAY 14'h0000
// Frame layout and checksum constants.
`define ETPG_HDR_LEN 14'h0010
`define ETPG_MAX_PAY 14'h2568
`define ETPG_DLY 4
`define ETPG_CRC_INIT 32'hFFFF_FFFF
`define ETPG_CRC_POLY 32'hEDB8_8320
`define ETPG_CRC_RES 32'hDEBB_20E3
`endif

/* File: hw/etpg_pkg.sv */
package etpg_pkg;
  // One byte beat of an Avalon-ST style byte stream.
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [7:0] data;
  } etpg_st_s;
  // Generator sequencing states.
  typedef enum logic [1:0] {G_IDLE, G_FRAME, G_FLUSH, G_CRC} etpg_gen_e;
endpackage : etpg_pkg

/* File: tb/etpg_mac_model.sv */
`timescale 1ns/1ps
// Loopback stand-in for the MAC: takes transmit beats and replays them.
module etpg_mac_model
  import etpg_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Transmit side, fed by the generator.
  input wire etpg_pkg::etpg_st_s tx,
  output logic tx_ready,
  // Receive side, towards the monitor.
  output etpg_pkg::etpg_st_s rx,
  // Test controls: stall every other cycle, damage the last byte.
  input wire logic slow,
  input wire logic corrupt
);
  // Ready toggles in slow mode so the source must hold its beats.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
  end
  // Replay each taken beat one cycle later.
  // Idle data keeps changing so stale bytes are never mistaken for beats.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx <= '0;
    end else if (tx.valid && tx_ready) begin
      rx <= '{1'b1, tx.sop, tx.eop, tx.data ^ {7'h00, corrupt && tx.eop}};
    end else begin
      rx <= '{1'b0, 1'b0, 1'b0, ~rx.data};
    end
  end
endmodule : etpg_mac_model

/* File: tb/etpg_top_bench.sv */
`timescale 1ns/1ps
`include "etpg_map.svh"
module etpg_top_bench;
  import etpg_pkg::*;
  logic mclk, rst_n, cyc, stb, we, slow, corrupt, tx_ready;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rd, wb_dat_o;
  logic wb_ack_o, rx_ready, pkt_good, pkt_bad, irq;
  etpg_st_s tx_o, rx_i;
  int failures = 0;
  int check_count = 0;
  int good_n = 0;
  int bad_n = 0;
  // Captured transmit bytes and the bytes we expect to see.
  logic [7:0] q[$];
  logic [7:0] e[$];
  logic [47:0] da = 48'h0200_1122_3344;
  logic [47:0] sa = 48'h0200_5566_7788;
  // Byte lanes used by the next bus cycle.
  logic [3:0] wsel = 4'hF;

  etpg_top u_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_o(tx_o),
    .tx_ready(tx_ready), .rx_i(rx_i), .rx_ready(rx_ready),
    .pkt_good(pkt_good), .pkt_bad(pkt_bad), .irq(irq));
  etpg_mac_model u_mac (.mclk(mclk), .rst_n(rst_n), .tx(tx_o),
    .tx_ready(tx_ready), .rx(rx_i), .slow(slow), .corrupt(corrupt));

  // Free-running system clock, 20 ns period.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Record every beat the MAC takes, and count verdict pulses.
  always @(posedge mclk) begin
    if (rst_n === 1'b1 && tx_o.valid === 1'b1 && tx_ready === 1'b1) begin
      q.push_back(tx_o.data);
    end
    if (pkt_good === 1'b1) begin
      good_n++;
    end
    if (pkt_bad === 1'b1) begin
      bad_n++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic Wishbone cycle; read data lands in rd.
  // Only the watchdog ends a wait for the acknowledge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= wsel;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  // Poll until generator and monitor are both idle, with a bound.
  task automatic drain;
    int i;
    i = 0;
    do begin
      wb(1'b0, `ETPG_GEN_STAT, 32'h0000_0000);
      i++;
    end while (rd[0] !== 1'b0 && i < 500);
    do begin
      wb(1'b0, `ETPG_MON_STAT, 32'h0000_0000);
      i++;
    end while (rd[0] !== 1'b0 && i < 1000);
    if (i >= 1000) begin
      failures++;
    end
  endtask : drain

  // Expected frame: addresses and fields msb first, CRC low byte first.
  task automatic exp_frame(input logic [15:0] seq, input int n);
    logic [7:0] f[$];
    logic [31:0] c;
    for (int i = 5; i >= 0; i--) f.push_back(da[i*8+:8]);
    for (int i = 5; i >= 0; i--) f.push_back(sa[i*8+:8]);
    f.push_back(8'h88);
    f.push_back(8'hB5);
    f.push_back(seq[15:8]);
    f.push_back(seq[7:0]);
    for (int i = 0; i < n; i++) f.push_back(i[7:0]);
    c = `ETPG_CRC_INIT;
    foreach (f[k]) begin
      c = c ^ {24'h00_0000, f[k]};
      repeat (8) c = c[0] ? (c >> 1) ^ `ETPG_CRC_POLY : c >> 1;
    end
    c = ~c;
    for (int i = 0; i < 4; i++) f.push_back(c[i*8+:8]);
    foreach (f[k]) e.push_back(f[k]);
  endtask : exp_frame

  // Compare the captured stream byte by byte, then start afresh.
  task automatic cmp_frames;
    chk(q.size(), e.size());
    foreach (e[k]) chk(q[k], e[k]);
    q.delete();
    e.delete();
  endtask : cmp_frames

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // A hung handshake ends here instead of running forever.
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    final_report;
  end

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0000_0000;
    slow = 1'b1;
    corrupt = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values, and a hole in the map that must read back zero.
    rdchk(`ETPG_GEN_TXCNT, 32'h0000_0000);
    rdchk(`ETPG_MON_GOOD, 32'h0000_0000);
    rdchk(`ETPG_IRQ_MASK, 32'h0000_0000);
    wb(1'b1, 8'h30, 32'hFFFF_FFFF);
    rdchk(8'h30, 32'h0000_0000);
    chk(irq, 32'h0000_0000);
    // A write with one byte lane selected touches only that byte.
    wsel = 4'h2;
    wb(1'b1, `ETPG_MON_EXP, 32'hFFFF_FFFF);
    wsel = 4'hF;
    rdchk(`ETPG_MON_EXP, 32'h0000_FF00);
    chk(rx_ready, 32'h0000_0001);
    $display("test reset done");
    // Two frames of three payload bytes with the MAC stalling.
    wb(1'b1, `ETPG_GEN_DA_HI, {16'h0000, da[47:32]});
    wb(1'b1, `ETPG_GEN_DA_LO, da[31:0]);
    wb(1'b1, `ETPG_GEN_SA_HI, {16'h0000, sa[47:32]});
    wb(1'b1, `ETPG_GEN_SA_LO, sa[31:0]);
    wb(1'b1, `ETPG_GEN_ETYPE, 32'h0000_88B5);
    wb(1'b1, `ETPG_GEN_PAY, 32'h0000_0003);
    wb(1'b1, `ETPG_GEN_NUM, 32'h0000_0002);
    wb(1'b1, `ETPG_MON_EXP, 32'h0000_0002);
    wb(1'b1, `ETPG_IRQ_MASK, 32'h0000_000F);
    wb(1'b1, `ETPG_MON_CTRL, 32'h0000_0001);
    wb(1'b1, `ETPG_GEN_CTRL, 32'h0000_0001);
    drain;
    exp_frame(16'h0000, 3);
    exp_frame(16'h0001, 3);
    cmp_frames;
    rdchk(`ETPG_GEN_TXCNT, 32'h0000_0002);
    rdchk(`ETPG_MON_GOOD, 32'h0000_0002);
    rdchk(`ETPG_MON_BAD, 32'h0000_0000);
    rdchk(`ETPG_MON_BYTES, 32'h0000_002E);
    chk(good_n, 32'h0000_0002);
    wb(1'b0, `ETPG_MON_CYC, 32'h0000_0000);
    chk(rd != 32'h0000_0000, 32'h0000_0001);
    rdchk(`ETPG_IRQ_STAT, 32'h0000_000B);
    chk(irq, 32'h0000_0001);
    wb(1'b1, `ETPG_IRQ_MASK, 32'h0000_0000);
    chk(irq, 32'h0000_0000);
    wb(1'b1, `ETPG_IRQ_MASK, 32'h0000_000F);
    wb(1'b1, `ETPG_IRQ_STAT, 32'h0000_000F);
    chk(irq, 32'h0000_0000);
    rdchk(`ETPG_IRQ_STAT, 32'h0000_0000);
    $display("test good frames done");
    // One empty-payload frame whose last byte the MAC damages.
    corrupt <= 1'b1;
    slow <= 1'b0;
    wb(1'b1, `ETPG_GEN_PAY, 32'h0000_0000);
    wb(1'b1, `ETPG_GEN_NUM, 32'h0000_0001);
    wb(1'b1, `ETPG_MON_EXP, 32'h0000_0001);
    rdchk(`ETPG_MON_EXP, 32'h0000_0001);
    wb(1'b1, `ETPG_MON_CTRL, 32'h0000_0001);
    rdchk(`ETPG_MON_STAT, 32'h0000_0001);
    wb(1'b1, `ETPG_GEN_CTRL, 32'h0000_0001);
    drain;
    exp_frame(16'h0002, 0);
    cmp_frames;
    chk(bad_n, 32'h0000_0001);
    rdchk(`ETPG_MON_BAD, 32'h0000_0001);
    rdchk(`ETPG_MON_GOOD, 32'h0000_0000);
    rdchk(`ETPG_IRQ_STAT, 32'h0000_000D);
    $display("test bad frame done");
    final_report;
  end
endmodule : etpg_top_bench
